// ---- sie_contact_model.sv ----
module sie_contact_model import sie_pkg::*; (
	input  wire logic       i_ref_clk,
	input  wire logic       i_act,
	input  wire sie_cont_t  i_cont,
	input  wire logic       i_bounce,
	input  wire logic       i_short,
	input  wire logic [1:0] i_test_out,
	output logic            o_ch1,
	output logic            o_ch2
);
	timeunit 1ns;
	timeprecision 1ns;
	logic tog = 1'b0;
	logic no1, nc2;
	// chatter source while bouncing
	always @(posedge i_ref_clk) tog <= ~tog;
	always_comb begin
		no1 = (i_cont == C_NCNO || i_cont == C_SNO || i_cont == C_DNO) ? i_act : ~i_act;
		nc2 = (i_cont == C_SNO || i_cont == C_DNO) ? i_act : ~i_act;
		// contacts fed from test lines, short pins channel 1 high
		o_ch1 = ((no1 & i_test_out[0]) ^ (i_bounce & tog)) | i_short;
		o_ch2 = nc2 & i_test_out[1];
	end
endmodule // sie_contact_model

// ---- sie_pkg.sv ----
package sie_pkg;
	// timing
	localparam int CLK_NS   = 10;
	localparam int MS_NS    = 1_000_000;
	localparam int MS_CYC   = (MS_NS + CLK_NS - 1) / CLK_NS;
	localparam int TP_CYC   = 4;
	localparam logic [7:0] FILT_MIN = 8'h03;
	localparam logic [7:0] FILT_MAX = 8'hfa;
	// register byte addresses
	localparam logic [11:0] A_CTRL   = 12'h000;
	localparam logic [11:0] A_FILT   = 12'h004;
	localparam logic [11:0] A_SIM    = 12'h008;
	localparam logic [11:0] A_STATUS = 12'h00c;
	localparam logic [11:0] A_CMD    = 12'h010;
	// field layout
	localparam int CTRL_W   = 13;
	localparam int CMD_CLR  = 0;
	localparam int ST_OUT   = 0;
	localparam int ST_FAULT = 1;
	localparam int ST_DB    = 2;
	localparam int ST_STATE = 4;
	// device kinds and contact sets
	typedef enum logic [2:0] {
		K_INTLK = 3'b000, K_LOCK = 3'b001, K_KEY = 3'b010,
		K_GRID = 3'b011, K_FOOT = 3'b100
	} sie_kind_t;
	typedef enum logic [2:0] {
		C_SNC = 3'b000, C_SNO = 3'b001, C_DNC = 3'b010,
		C_DNO = 3'b011, C_NCNO = 3'b100
	} sie_cont_t;
	typedef enum logic [1:0] {
		R_NONE = 2'b00, R_MAN = 2'b01, R_MON = 2'b10
	} sie_rmode_t;
	typedef enum logic [2:0] {
		S_START = 3'b000, S_IDLE = 3'b001, S_ARM = 3'b010,
		S_REL = 3'b011, S_ON = 3'b100
	} sie_state_t;
	typedef struct packed {
		logic [1:0] test_en;
		logic       err_en;
		logic       sim_en;
		logic       start_en;
		sie_rmode_t rmode;
		sie_cont_t  cont;
		sie_kind_t  kind;
	} sie_cfg_t;
	// reset values
	localparam sie_cfg_t CFG_RST = '{2'b00, 1'b1, 1'b1, 1'b1, R_NONE, C_DNC, K_INTLK};
	localparam logic [7:0]  FILT_RST = 8'h0a;
	localparam logic [15:0] SIM_RST  = 16'h0064;
endpackage

// ---- sie_top.sv ----
// Notes on behaviour
// - manual reset: one rising edge enables
// - monitored reset: rise then fall enables
// - no reset: output follows input condition
// - debounce each channel, 3 to 250 ms
// - two channels must agree within limit
// - after power-on, full device cycle first
// - error flag shows detected input faults
// - test pulses out, checked on return
// - guard lock feedback: locked gives low
// - lock feedback: NC, 2NC, NC plus NO
// - key switch: turned gives high, NO contacts
// - light grid: high only when both high
// - light grid never uses test pulses
// - footswitch: pressed gives high
// - footswitch: NC, NO, 2NC, NC plus NO
module sie_top import sie_pkg::*; #(
	parameter int P_MS_CYC = MS_CYC
) (
	input  wire logic        i_ref_clk,
	input  wire logic        i_reset,
	input  wire logic        i_psel,
	input  wire logic        i_penable,
	input  wire logic        i_pwrite,
	input  wire logic [11:0] i_paddr,
	input  wire logic [31:0] i_pwdata,
	input  wire logic        i_first_channel_input,
	input  wire logic        i_second_channel_input,
	input  wire logic        i_reset_input,
	output logic             o_pready,
	output logic             o_pslverr,
	output logic [31:0]      o_prdata,
	output logic             o_safe_out,
	output logic             o_error,
	output logic [1:0]       o_test_out
);

	// clamp the filter setting to its legal span
	function automatic logic [7:0] filt_lim(input logic [7:0] f);
		if (f < FILT_MIN) return FILT_MIN;
		if (f > FILT_MAX) return FILT_MAX;
		return f;
	endfunction

	// interlock and lock feedback report safe when idle
	function automatic logic kind_inv(input sie_kind_t k);
		return (k == K_INTLK) || (k == K_LOCK);
	endfunction

	sie_cfg_t    cfg, next_cfg;
	logic [7:0]  filt, next_filt;
	logic [15:0] simv, next_simv;
	logic        next_pready, next_pslverr;
	logic [31:0] next_prdata;
	logic        wr, clr_req, setup;
	logic [19:0] tcnt, next_tcnt;
	logic        ms_par, next_ms_par, tick, hold, tp_err;
	logic [1:0]  pulse, next_test, raw, db, next_db;
	logic [7:0]  scnt [2];
	logic [7:0]  next_scnt [2];
	logic [7:0]  flim;
	logic [1:0]  n;
	logic        two, cond, mism, sim_err;
	logic [15:0] simc, next_simc;
	logic        fault, next_fault, rst_q;
	logic        start_seen, next_start_seen;
	sie_state_t  state, next_state;

	// apb slave: registered answer, no wait states
	always_comb begin
		setup        = i_psel & ~i_penable;
		wr           = i_psel & i_penable & o_pready & i_pwrite;
		clr_req      = wr && (i_paddr == A_CMD) && i_pwdata[CMD_CLR];
		next_cfg     = cfg;
		next_filt    = filt;
		next_simv    = simv;
		next_pready  = setup;
		next_prdata  = o_prdata;
		next_pslverr = 1'b0;
		if (wr) begin
			unique case (i_paddr)
				A_CTRL: next_cfg = sie_cfg_t'(i_pwdata[CTRL_W-1:0]);
				A_FILT: next_filt = filt_lim(i_pwdata[7:0]);
				A_SIM:  next_simv = i_pwdata[15:0];
				default: ;
			endcase
		end
		if (setup) begin
			next_prdata = 32'h0000_0000;
			unique case (i_paddr)
				A_CTRL: next_prdata[CTRL_W-1:0] = cfg;
				A_FILT: next_prdata[7:0] = filt;
				A_SIM:  next_prdata[15:0] = simv;
				A_STATUS: begin
					next_prdata[ST_OUT]            = o_safe_out;
					next_prdata[ST_FAULT]          = fault;
					next_prdata[ST_DB+1:ST_DB]     = db;
					next_prdata[ST_STATE+2:ST_STATE] = state;
				end
				A_CMD: ;
				default: next_pslverr = 1'b1;
			endcase
		end
	end

	always_ff @(posedge i_ref_clk) begin
		if (i_reset) begin
			cfg       <= CFG_RST;
			filt      <= FILT_RST;
			simv      <= SIM_RST;
			o_pready  <= 1'b0;
			o_pslverr <= 1'b0;
			o_prdata  <= 32'h0000_0000;
		end else begin
			cfg       <= next_cfg;
			filt      <= next_filt;
			simv      <= next_simv;
			o_pready  <= next_pready;
			o_pslverr <= next_pslverr;
			o_prdata  <= next_prdata;
		end
	end

	// millisecond tick and test pulse timing
	always_comb begin
		tick        = (tcnt == 20'(P_MS_CYC - 1));
		next_tcnt   = tick ? 20'h00000 : tcnt + 20'h00001;
		next_ms_par = ms_par ^ tick;
		raw         = {i_second_channel_input, i_first_channel_input};
		for (int c = 0; c < 2; c++) begin
			pulse[c] = (ms_par == c[0]) && (tcnt < 20'(TP_CYC))
				&& cfg.test_en[c] && (cfg.kind != K_GRID);
		end
		next_test = ~pulse;
		hold      = (tcnt <= 20'(TP_CYC)) && (cfg.test_en != 2'b00);
		// input high during own pulse: short
		tp_err = (tcnt == 20'(TP_CYC)) && ((~o_test_out & raw) != 2'b00);
	end

	// debounce in whole milliseconds
	always_comb begin
		flim = filt_lim(filt);
		next_db = db;
		for (int c = 0; c < 2; c++) begin
			next_scnt[c] = scnt[c];
			if (hold) begin
				next_scnt[c] = scnt[c];
			end else if (raw[c] == db[c]) begin
				next_scnt[c] = 8'h00;
			end else if (tick) begin
				if (scnt[c] + 8'h01 >= flim) begin
					next_db[c]   = raw[c];
					next_scnt[c] = 8'h00;
				end else begin
					next_scnt[c] = scnt[c] + 8'h01;
				end
			end
		end
	end

	always_ff @(posedge i_ref_clk) begin
		if (i_reset) begin
			tcnt       <= 20'h00000;
			ms_par     <= 1'b0;
			o_test_out <= 2'b11;
			db         <= 2'b00;
			scnt[0]    <= 8'h00;
			scnt[1]    <= 8'h00;
		end else begin
			tcnt       <= next_tcnt;
			ms_par     <= next_ms_par;
			o_test_out <= next_test;
			db         <= next_db;
			scnt[0]    <= next_scnt[0];
			scnt[1]    <= next_scnt[1];
		end
	end

	// contact decode, agreement check and fault latch
	always_comb begin
		two = (cfg.cont == C_DNC) || (cfg.cont == C_DNO) || (cfg.cont == C_NCNO);
		n[0] = (cfg.cont == C_SNO || cfg.cont == C_DNO || cfg.cont == C_NCNO)
			? db[0] : ~db[0];
		n[1] = (cfg.cont == C_DNO) ? db[1] : ~db[1];
		if (kind_inv(cfg.kind)) begin
			cond = two ? (~n[0] & ~n[1]) : ~n[0];
		end else begin
			cond = two ? (n[0] & n[1]) : n[0];
		end
		mism      = two & (n[0] ^ n[1]);
		next_simc = simc;
		if (!mism) begin
			next_simc = 16'h0000;
		end else if (tick && simc != 16'hffff) begin
			next_simc = simc + 16'h0001;
		end
		sim_err = cfg.sim_en & mism & (simc > simv);
		next_fault = sim_err | tp_err | (fault & ~clr_req);
	end

	// reset handling and power-on test
	always_comb begin
		next_state = state;
		// device seen ready before its cycle
		next_start_seen = start_seen | ((state == S_START) & cond);
		if (next_fault) begin
			next_state = S_IDLE;
		end else begin
			unique case (state)
				// wait for device to go inactive
				S_START: if (!cfg.start_en || (start_seen && !cond)) next_state = S_IDLE;
				// no reset option goes straight on
				S_IDLE: if (cond) next_state = (cfg.rmode == R_NONE) ? S_ON : S_ARM;
				S_ARM: begin
					if (!cond) begin
						next_state = S_IDLE;
					end else if (cfg.rmode == R_NONE) begin
						next_state = S_ON;
					end else if (i_reset_input && !rst_q) begin
						next_state = (cfg.rmode == R_MAN) ? S_ON : S_REL;
					end
				end
				S_REL: begin
					if (!cond) begin
						next_state = S_IDLE;
					end else if (!i_reset_input || cfg.rmode == R_NONE) begin
						next_state = S_ON;
					end
				end
				S_ON: if (!cond) next_state = S_IDLE;
				default: next_state = S_IDLE;
			endcase
		end
	end

	always_ff @(posedge i_ref_clk) begin
		if (i_reset) begin
			simc       <= 16'h0000;
			fault      <= 1'b0;
			rst_q      <= 1'b0;
			start_seen <= 1'b0;
			state      <= S_START;
			o_safe_out <= 1'b0;
			o_error    <= 1'b0;
		end else begin
			simc       <= next_simc;
			fault      <= next_fault;
			rst_q      <= i_reset_input;
			start_seen <= next_start_seen;
			state      <= next_state;
			o_safe_out <= (next_state == S_ON);
			o_error    <= next_fault & cfg.err_en;
		end
	end

	// checks
	default clocking cb @(posedge i_ref_clk); endclocking
	default disable iff (i_reset);

	sequence s_arm_rise;
		state == S_ARM && cond && !next_fault && i_reset_input && !rst_q;
	endsequence
	sequence s_rel_fall;
		state == S_REL && cond && !next_fault && !i_reset_input;
	endsequence

	property p_man;
		s_arm_rise and (cfg.rmode == R_MAN) |=> o_safe_out;
	endproperty
	a_man: assert property (p_man) else $error("manual reset edge ignored");
	property p_mon;
		s_arm_rise and (cfg.rmode == R_MON) |=> !o_safe_out ##0 (state == S_REL);
	endproperty
	a_mon: assert property (p_mon) else $error("monitored reset enabled early");
	property p_mon_fall;
		s_rel_fall |=> o_safe_out;
	endproperty
	a_mon_fall: assert property (p_mon_fall) else $error("reset fall not taken");
	property p_none;
		cfg.rmode == R_NONE && state == S_IDLE && cond && !next_fault |=> o_safe_out;
	endproperty
	a_none: assert property (p_none) else $error("output not following input");
	property p_filt;
		$changed(db[0]) |-> $past(scnt[0]) + 8'h01 >= $past(flim) && $past(tick);
	endproperty
	a_filt: assert property (p_filt) else $error("debounce accepted early");
	property p_sim;
		cfg.sim_en && mism && simc > simv |=> fault && !o_safe_out;
	endproperty
	a_sim: assert property (p_sim) else $error("simultaneity fault missed");
	property p_start;
		state == S_START && cfg.start_en && !start_seen && !next_fault |=> state == S_START;
	endproperty
	a_start: assert property (p_start) else $error("output on before function test");
	property p_err;
		$rose(fault) && $past(cfg.err_en) |-> o_error;
	endproperty
	a_err: assert property (p_err) else $error("error flag not raised");
	property p_tp;
		tp_err |=> fault ##1 !o_safe_out;
	endproperty
	a_tp: assert property (p_tp) else $error("test pulse fault missed");
	property p_grid;
		cfg.kind == K_GRID |=> o_test_out == 2'b11;
	endproperty
	a_grid: assert property (p_grid) else $error("grid got test pulses");
	property p_grid_out;
		o_safe_out && $past(cfg.kind == K_GRID && cfg.cont == C_DNO) |-> $past(db) == 2'b11;
	endproperty
	a_grid_out: assert property (p_grid_out) else $error("grid on while interrupted");
	property p_fault;
		fault |-> !o_safe_out;
	endproperty
	a_fault: assert property (p_fault) else $error("output on during fault");

endmodule // sie_top

// ---- testbench.sv ----
module testbench import sie_pkg::*;;
	timeunit 1ns;
	timeprecision 1ns;
	logic        clk = 0, rst = 1, psel = 0, pen = 0, pwr = 0;
	logic        act = 0, bnc = 0, sht = 0, rin = 0;
	logic [11:0] padr = '0;
	logic [31:0] pwd = '0, rv;
	logic [33:0] me;
	wire logic   rdy, serr, sout, err, ch1, ch2;
	wire [31:0]  rdat;
	wire [1:0]   tout;
	sie_cont_t   cont = C_DNC;
	sie_cfg_t    cfg;
	int          num_errors = 0, comparisons = 0, lowc;
	logic [33:0] q[$];
	logic [6:0]  tbl [12] = '{7'h04, 7'h08, 7'h10, 7'h14, 7'h18, 7'h23,
		7'h27, 7'h37, 7'h41, 7'h43, 7'h45, 7'h49};

	always #5 clk = ~clk;

	sie_top #(.P_MS_CYC(20)) dut_u (.i_ref_clk(clk), .i_reset(rst), .i_psel(psel),
		.i_penable(pen), .i_pwrite(pwr), .i_paddr(padr), .i_pwdata(pwd),
		.i_first_channel_input(ch1), .i_second_channel_input(ch2),
		.i_reset_input(rin), .o_pready(rdy), .o_pslverr(serr), .o_prdata(rdat),
		.o_safe_out(sout), .o_error(err), .o_test_out(tout));
	sie_contact_model cm_u (.i_ref_clk(clk), .i_act(act), .i_cont(cont), .i_bounce(bnc),
		.i_short(sht), .i_test_out(tout), .o_ch1(ch1), .o_ch2(ch2));

	// answer checker, oldest note first
	always @(posedge clk) if (rdy === 1'b1) begin
		me = q.pop_front();
		comparisons++;
		if (serr !== me[32] || (me[33] && rdat !== me[31:0])) begin
			num_errors++;
			$display("wrong value apb answer expected %h seen %h", me, {1'b1, serr, rdat});
		end
	end

	task finish_test;
		if (num_errors == 0 && comparisons > 0) $display("TEST PASSED");
		else $display("TEST FAILED");
		$finish;
	endtask

	task apb(input logic w, input logic [11:0] a, input logic [31:0] d, input logic [33:0] ex);
		q.push_back(ex);
		@(posedge clk);
		psel <= 1;
		pen <= 0;
		pwr <= w;
		padr <= a;
		pwd <= d;
		@(posedge clk);
		pen <= 1;
		// hold the access until pready is seen at an edge
		do @(posedge clk); while (rdy !== 1'b1);
		psel <= 0;
		pen <= 0;
	endtask

	task wr(input logic [11:0] a, input logic [31:0] d);
		apb(1, a, d, '0);
	endtask

	task rd(input logic [11:0] a, input logic [31:0] v);
		apb(0, a, '0, {2'b10, v});
	endtask

	task cfgw(input sie_kind_t k, input sie_cont_t c, input sie_rmode_t r, input logic [1:0] t);
		cfg = '{t, 1'b1, 1'b1, 1'b0, r, c, k};
		wr(A_CTRL, 32'(cfg));
		cont <= c;
	endtask

	// wait bounded for output and flag levels
	task chk(input logic eo, input logic ee, input int n);
		int i;
		i = 0;
		while ((sout !== eo || err !== ee) && i < n) begin
			@(posedge clk);
			i++;
		end
		comparisons++;
		if (sout !== eo || err !== ee) begin
			num_errors++;
			$display("wrong value out,error expected %b%b seen %b%b", eo, ee, sout, err);
		end
	endtask

	task ms(input int n);
		repeat (n * 20) @(posedge clk);
	endtask

	// watchdog
	initial begin
		repeat (40000) @(posedge clk);
		num_errors++;
		finish_test;
	end

	// main sequence
	initial begin
		rv = $urandom(32'hfc68bda0);
		repeat (5) @(posedge clk);
		rst <= 0;
		rd(A_CTRL, 32'(CFG_RST));
		rd(A_FILT, {24'h0, FILT_RST});
		rd(A_SIM, {16'h0, SIM_RST});
		apb(0, 12'h020, '0, {2'b11, 32'h0});
		ms(30);
		chk(0, 0, 1);
		act <= 1;
		ms(15);
		act <= 0;
		chk(1, 0, 600);
		wr(A_FILT, 32'h1);
		rd(A_FILT, {24'h0, FILT_MIN});
		wr(A_FILT, 32'hff);
		rd(A_FILT, {24'h0, FILT_MAX});
		wr(A_SIM, rv);
		rd(A_SIM, {16'h0, rv[15:0]});
		wr(A_FILT, 32'h3);
		wr(A_SIM, 32'h5);
		bnc <= 1;
		ms(2);
		bnc <= 0;
		chk(1, 0, 1);
		act <= 1;
		ms(1);
		chk(1, 0, 1);
		chk(0, 0, 100);
		foreach (tbl[i]) begin
			cfgw(sie_kind_t'(tbl[i][6:4]), sie_cont_t'(tbl[i][3:1]), R_NONE, 2'b00);
			act <= 0;
			chk(~tbl[i][0], 0, 300);
			act <= 1;
			chk(tbl[i][0], 0, 300);
		end
		cfgw(K_INTLK, C_DNC, R_MAN, 2'b00);
		ms(8);
		act <= 0;
		ms(8);
		chk(0, 0, 1);
		rin <= 1;
		chk(1, 0, 3);
		rin <= 0;
		cfgw(K_INTLK, C_DNC, R_MON, 2'b00);
		act <= 1;
		ms(8);
		act <= 0;
		ms(8);
		rin <= 1;
		ms(1);
		chk(0, 0, 1);
		rin <= 0;
		chk(1, 0, 3);
		sht <= 1;
		act <= 1;
		chk(0, 1, 400);
		sht <= 0;
		act <= 0;
		ms(8);
		chk(0, 1, 1);
		wr(A_CMD, 32'h1);
		cfgw(K_INTLK, C_DNC, R_NONE, 2'b11);
		chk(1, 0, 300);
		sht <= 1;
		chk(0, 1, 200);
		sht <= 0;
		wr(A_CMD, 32'h1);
		cfgw(K_GRID, C_DNO, R_NONE, 2'b11);
		ms(1);
		lowc = 0;
		repeat (60) @(posedge clk) if (tout !== 2'b11) lowc++;
		comparisons++;
		if (lowc != 0) begin
			num_errors++;
			$display("wrong value test_out low cycles expected 0 seen %0d", lowc);
		end
		finish_test;
	end
endmodule // testbench
